/* ioser_top.sv */
// i/o ordering barrier, refetch barrier and full barrier sequencing
module ioser_top
  import ioser_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // configuration from impl_control_reg_zero
  input  wire logic        address_broadcast_enable,
  // dispatch
  input  wire ioser_disp_t disp,
  output logic             disp_ready,
  output logic             barrier_done,
  // load_store_unit status
  input  wire logic        ciwt_performed,
  input  wire logic        older_done,
  // store queue and fetch
  output logic             sq_fence,
  output logic             ifq_flush,
  output logic             fetch_hold,
  // bus interface unit
  output ioser_bus_t       bus,
  input  wire logic        bus_ack,
  input  wire logic        bus_ok
);
  ioser_state_t    state_r;
  ioser_state_t    state_nxt;
  logic            abe_r;
  logic            done_r;
  logic            fence_r;
  logic            flush_r;
  logic            hold_r;
  ioser_bus_kind_t kind_r;
  logic            cnt_zero;
  logic            fire;
  logic            ciwt_fire;
  logic            in_bus;

  // true for an opcode that orders against the i/o barrier
  function automatic logic is_ordered(input ioser_op_t op);
    is_ordered = (op == IOSER_OP_CIWT) || (op == IOSER_OP_EIO) ||
                 (op == IOSER_OP_RFB)  || (op == IOSER_OP_FMB);
  endfunction

  // dispatch decode: ordered ops only accepted while idle
  assign fire       = disp.valid && disp_ready;
  assign ciwt_fire  = fire && (disp.op == IOSER_OP_CIWT);
  assign disp_ready = !is_ordered(disp.op) || (state_r == IOSER_IDLE);
  assign in_bus     = (state_r == IOSER_EI_BUS) || (state_r == IOSER_SY_BUS);

  // outputs
  assign barrier_done  = done_r;
  assign sq_fence      = fence_r;
  assign ifq_flush     = flush_r;
  assign fetch_hold    = hold_r;
  assign bus.req       = in_bus;
  assign bus.kind      = kind_r;
  assign bus.l2_bypass = in_bus;

  // outstanding ci/wt accesses, issued in order and performed in order
  ioser_cnt u_cnt (
    .clk   (clk),
    .rst   (rst),
    .inc   (ciwt_fire),
    .dec   (ciwt_performed),
    .count (),
    .zero  (cnt_zero)
  );

  // barrier sequencer
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      IOSER_IDLE:
      begin
        if (fire && disp.op == IOSER_OP_EIO)
          state_nxt = IOSER_EI_DRAIN;
        else if (fire && disp.op == IOSER_OP_RFB)
          state_nxt = IOSER_IS_WAIT;
        else if (fire && disp.op == IOSER_OP_FMB)
          state_nxt = IOSER_SY_DRAIN;
      end
      IOSER_EI_DRAIN:
      begin
        if (cnt_zero)
          state_nxt = abe_r ? IOSER_EI_BUS : IOSER_IDLE;
      end
      IOSER_EI_BUS:
      begin
        if (bus_ack)
          state_nxt = IOSER_IDLE;
      end
      IOSER_IS_WAIT:
      begin
        if (older_done)
          state_nxt = IOSER_IDLE;
      end
      IOSER_SY_DRAIN:
      begin
        if (cnt_zero && older_done)
          state_nxt = abe_r ? IOSER_SY_BUS : IOSER_IDLE;
      end
      IOSER_SY_BUS:
      begin
        if (bus_ack && bus_ok)
          state_nxt = IOSER_IDLE;
      end
      default:
        state_nxt = IOSER_IDLE;
    endcase
  end

  // state and configuration sample
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= IOSER_IDLE;
      abe_r   <= `IOSER_ABE_RST;
    end
    else
    begin
      state_r <= state_nxt;
      if (fire && is_ordered(disp.op) && disp.op != IOSER_OP_CIWT)
        abe_r <= address_broadcast_enable;
    end
  end

  // completion pulse when a barrier sequence returns to idle
  always_ff @(posedge clk)
  begin
    if (rst)
      done_r <= 1'b0;
    else
      done_r <= (state_r != IOSER_IDLE) && (state_nxt == IOSER_IDLE);
  end

  // store queue fence and instruction queue flush pulses
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fence_r <= 1'b0;
      flush_r <= 1'b0;
    end
    else
    begin
      fence_r <= fire && (disp.op == IOSER_OP_EIO);
      flush_r <= fire && (disp.op == IOSER_OP_RFB);
    end
  end

  // fetch held from refetch barrier dispatch until older work is done
  always_ff @(posedge clk)
  begin
    if (rst)
      hold_r <= 1'b0;
    else if (fire && disp.op == IOSER_OP_RFB)
      hold_r <= 1'b1;
    else if (state_r == IOSER_IS_WAIT && older_done)
      hold_r <= 1'b0;
  end

  // bus operation kind chosen on entry to a bus state
  always_ff @(posedge clk)
  begin
    if (rst)
      kind_r <= IOSER_BUS_EIO;
    else if (state_nxt == IOSER_SY_BUS)
      kind_r <= IOSER_BUS_FMB;
    else if (state_nxt == IOSER_EI_BUS)
      kind_r <= IOSER_BUS_EIO;
  end

  // checks
  AST_EI_DRAIN_WAIT: assert property (@(posedge clk) disable iff (rst)
    state_r == IOSER_EI_DRAIN && !cnt_zero |=> state_r == IOSER_EI_DRAIN)
    else $error("i/o barrier left drain with accesses outstanding");
  AST_CIWT_STALL: assert property (@(posedge clk) disable iff (rst)
    disp.valid && disp.op == IOSER_OP_CIWT && state_r != IOSER_IDLE |-> !disp_ready)
    else $error("ci/wt access accepted behind a barrier");
  AST_EI_BROADCAST: assert property (@(posedge clk) disable iff (rst)
    state_r == IOSER_EI_DRAIN && cnt_zero && abe_r |=> bus.req && bus.kind == IOSER_BUS_EIO)
    else $error("i/o barrier did not broadcast");
  AST_BYPASS_L2: assert property (@(posedge clk) disable iff (rst)
    bus.req |-> bus.l2_bypass)
    else $error("bus ordering operation not bypassing l2");
  AST_NO_BUS_ABE0: assert property (@(posedge clk) disable iff (rst)
    state_r == IOSER_EI_DRAIN && cnt_zero && !abe_r |=> !bus.req ##1 !bus.req)
    else $error("bus transaction with broadcast disabled");
  AST_FENCE: assert property (@(posedge clk) disable iff (rst)
    fire && disp.op == IOSER_OP_EIO |=> sq_fence ##1 !sq_fence)
    else $error("store queue fence missing");
  AST_RFB_FLUSH: assert property (@(posedge clk) disable iff (rst)
    fire && disp.op == IOSER_OP_RFB |=> ifq_flush && fetch_hold)
    else $error("refetch barrier did not flush and hold");
  AST_RFB_HOLD: assert property (@(posedge clk) disable iff (rst)
    state_r == IOSER_IS_WAIT && !older_done |=> fetch_hold)
    else $error("fetch released before older instructions done");
  AST_FMB_RETRY: assert property (@(posedge clk) disable iff (rst)
    state_r == IOSER_SY_BUS && bus_ack && !bus_ok |=> !barrier_done && bus.req)
    else $error("full barrier completed on failed broadcast");
  COV_EI_BUS: cover property (@(posedge clk) disable iff (rst)
    state_r == IOSER_EI_BUS && bus_ack);
  COV_RFB: cover property (@(posedge clk) disable iff (rst)
    state_r == IOSER_IS_WAIT && older_done);
  COV_FMB_RETRY: cover property (@(posedge clk) disable iff (rst)
    state_r == IOSER_SY_BUS && bus_ack && !bus_ok);
endmodule

/* ioser_map.svh */
// widths and reset values for the i/o ordering and refetch barrier block
`ifndef IOSER_MAP_SVH
`define IOSER_MAP_SVH
`define IOSER_CNT_W      4
`define IOSER_CNT_RST    4'h0
`define IOSER_ST_W       3
`define IOSER_OP_W       3
`define IOSER_ABE_RST    1'b0
`endif

/* ioser_pkg.sv */
// types shared by the i/o ordering and refetch barrier block
`include "ioser_map.svh"
package ioser_pkg;
  typedef enum logic [`IOSER_OP_W-1:0] {
    IOSER_OP_OTHER = 3'h0,
    IOSER_OP_CIWT  = 3'h1,
    IOSER_OP_EIO   = 3'h2,
    IOSER_OP_RFB   = 3'h3,
    IOSER_OP_FMB   = 3'h4
  } ioser_op_t;

  typedef enum logic [`IOSER_ST_W-1:0] {
    IOSER_IDLE     = 3'h0,
    IOSER_EI_DRAIN = 3'h1,
    IOSER_EI_BUS   = 3'h2,
    IOSER_IS_WAIT  = 3'h3,
    IOSER_SY_DRAIN = 3'h4,
    IOSER_SY_BUS   = 3'h5
  } ioser_state_t;

  typedef enum logic {
    IOSER_BUS_EIO = 1'b0,
    IOSER_BUS_FMB = 1'b1
  } ioser_bus_kind_t;

  // dispatch request toward the load_store_unit
  typedef struct packed {
    logic      valid;
    ioser_op_t op;
  } ioser_disp_t;

  // request handed straight to the bus interface unit
  typedef struct packed {
    logic            req;
    ioser_bus_kind_t kind;
    logic            l2_bypass;
  } ioser_bus_t;
endpackage

/* ioser_cnt.sv */
// counter of cache-inhibited or write-through accesses issued and not yet performed
module ioser_cnt
  import ioser_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // events
  input  wire logic                   inc,
  input  wire logic                   dec,
  // state
  output logic [`IOSER_CNT_W-1:0]     count,
  output logic                        zero
);
  logic [`IOSER_CNT_W-1:0] cnt_r;
  logic [`IOSER_CNT_W-1:0] cnt_nxt;

  // issue and perform in one cycle cancel out
  assign cnt_nxt = (inc && !dec) ? cnt_r + `IOSER_CNT_W'(1) :
                   (dec && !inc) ? cnt_r - `IOSER_CNT_W'(1) : cnt_r;
  assign count   = cnt_r;
  assign zero    = (cnt_r == `IOSER_CNT_RST);

  // count register
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_r <= `IOSER_CNT_RST;
    else
      cnt_r <= cnt_nxt;
  end
endmodule

/* ioser_bus_model.sv */
// behavioural bus interface unit and external memory system
module ioser_bus_model
  import ioser_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // bus request from the barrier block
  input  wire ioser_bus_t bus,
  // refuse the first broadcast once
  input  wire logic       nack_once,
  // answer
  output logic            bus_ack,
  output logic            bus_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_r;
  logic       nacked_r;
  logic       ok_r;
  logic       junk_r;
  // answer after a short wait, refusing one answer when nack_once is set
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wait_r   <= 2'h0;
      nacked_r <= 1'b0;
      bus_ack  <= 1'b0;
      ok_r     <= 1'b0;
    end
    else if (bus_ack)
    begin
      bus_ack <= 1'b0;
      wait_r  <= 2'h0;
    end
    else if (bus.req)
    begin
      wait_r  <= wait_r + 2'h1;
      bus_ack <= (wait_r == 2'h2);
      if (wait_r == 2'h2)
      begin
        ok_r     <= !(nack_once && !nacked_r);
        nacked_r <= nacked_r | nack_once;
      end
    end
  end
  // status means nothing outside the answer cycle
  assign bus_ok = bus_ack ? ok_r : junk_r;
  // filler status toggles outside answers, so nothing may read it there
  always_ff @(posedge clk)
  begin
    if (rst)
      junk_r <= 1'b0;
    else
      junk_r <= ~junk_r;
  end
endmodule

/* tb_io_ordering_serialization.sv */
// self-checking bench for the barrier sequencer
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t %s", $time, m); end end
module tb_io_ordering_serialization import ioser_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, abe, ciwt_performed, older_done, nack_once;
  logic        disp_ready, barrier_done, sq_fence, ifq_flush, fetch_hold;
  logic        bus_ack, bus_ok;
  ioser_disp_t disp;
  ioser_bus_t  bus;
  int          num_errors, tests_run, n, r, a;
  // clock and design
  always #10 clk = ~clk;
  ioser_top dut_u (.clk(clk), .rst(rst), .address_broadcast_enable(abe), .disp(disp),
    .disp_ready(disp_ready), .barrier_done(barrier_done), .ciwt_performed(ciwt_performed),
    .older_done(older_done), .sq_fence(sq_fence), .ifq_flush(ifq_flush),
    .fetch_hold(fetch_hold), .bus(bus), .bus_ack(bus_ack), .bus_ok(bus_ok));
  ioser_bus_model bus_u (.clk(clk), .rst(rst), .bus(bus), .nack_once(nack_once),
    .bus_ack(bus_ack), .bus_ok(bus_ok));
  task end_sim;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  // one accepted dispatch, ends in the cycle after the take
  task send(input ioser_op_t op);
    disp = '{1'b1, op};
    #1;
    `CHK(disp_ready, 1'b1, "dispatch refused")
    tick;
    disp.valid = 1'b0;
  endtask
  // wait for completion, counting requests and answers seen
  task wait_done;
    n = 0;
    r = 0;
    a = 0;
    while (barrier_done !== 1'b1 && n < 60)
    begin
      if (bus.req === 1'b1) r++;
      if (bus_ack === 1'b1) a++;
      tick;
      n++;
    end
    `CHK(barrier_done, 1'b1, "no completion")
  endtask
  task eio_quiet;
    abe = 1'b0;
    send(IOSER_OP_EIO);
    abe = 1'b1;
    `CHK(sq_fence, 1'b1, "no gather fence")
    wait_done;
    `CHK(r, 0, "bus used without broadcast")
    `CHK(n <= 2, 1'b1, "slow with nothing pending")
  endtask
  task eio_bcast;
    send(IOSER_OP_CIWT);
    tick;
    send(IOSER_OP_EIO);
    repeat (3)
    begin
      `CHK(bus.req, 1'b0, "barrier ran ahead of access")
      tick;
    end
    disp = '{1'b1, IOSER_OP_CIWT};
    #1;
    `CHK(disp_ready, 1'b0, "later access taken")
    tick;
    disp.valid = 1'b0;
    ciwt_performed = 1'b1;
    tick;
    ciwt_performed = 1'b0;
    n = 0;
    while (bus.req !== 1'b1 && n < 10)
    begin
      tick;
      n++;
    end
    `CHK(bus.req, 1'b1, "no broadcast")
    `CHK(bus.kind, IOSER_BUS_EIO, "wrong op kind")
    `CHK(bus.l2_bypass, 1'b1, "cache not bypassed")
    wait_done;
    `CHK(a, 1, "done before answer")
  endtask
  task refetch;
    send(IOSER_OP_CIWT);
    older_done = 1'b0;
    tick;
    send(IOSER_OP_RFB);
    `CHK(ifq_flush, 1'b1, "queue not flushed")
    `CHK(fetch_hold, 1'b1, "fetch not held")
    repeat (4) tick;
    `CHK(fetch_hold, 1'b1, "fetch resumed early")
    `CHK(barrier_done, 1'b0, "done early")
    older_done = 1'b1;
    wait_done;
    `CHK(fetch_hold, 1'b0, "fetch still held")
    `CHK(n <= 2, 1'b1, "refetch waited on queued access")
    ciwt_performed = 1'b1;
    tick;
    ciwt_performed = 1'b0;
  endtask
  task full_bar;
    abe = 1'b1;
    nack_once = 1'b1;
    send(IOSER_OP_FMB);
    tick;
    `CHK(bus.req, 1'b1, "full barrier not broadcast")
    `CHK(bus.kind, IOSER_BUS_FMB, "wrong op kind")
    wait_done;
    `CHK(a, 2, "done after failed broadcast")
    nack_once = 1'b0;
    abe = 1'b0;
    tick;
    send(IOSER_OP_FMB);
    wait_done;
    `CHK(r, 0, "bus used without broadcast")
  endtask
  // watchdog
  initial
  begin
    #100000;
    num_errors++;
    end_sim;
  end
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    abe = 1'b0;
    disp = '0;
    ciwt_performed = 1'b0;
    older_done = 1'b1;
    nack_once = 1'b0;
    num_errors = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK(bus.req, 1'b0, "bus busy after reset")
    eio_quiet;
    tick;
    eio_bcast;
    tick;
    refetch;
    tick;
    full_bar;
    end_sim;
  end
endmodule
